// ### pkg/rcpl_pkg.sv
// Constants and types shared by the reset, configuration and lock block
`default_nettype none
package rcpl_pkg;
  localparam int unsigned CFG_W          = 8;
  localparam int unsigned SETUP_CYCLES   = 20;
  localparam logic [4:0]  SETUP_LAST     = 5'h13;
  localparam int unsigned LOCK_MAX_CYC   = 50000;
  localparam int unsigned LOCK_DIV       = 50;
  localparam int unsigned UNLOCK_DIV     = 25;
  localparam logic [15:0] LP_DIV_MAX     = 16'h8000;
  localparam logic [15:0] LP_DIV_MIN     = 16'h0001;
  localparam logic        RST_OUT_RST    = 1'b0;
  localparam logic [7:0]  CFG_RST        = 8'h00;

  typedef struct packed {
    logic        valid;
    logic [15:0] count;
  } rcpl_meas_t;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_SETUP,
    ST_RUN
  } rcpl_state_t;
endpackage : rcpl_pkg
`default_nettype wire

// ### hw/rcpl_top.sv
// Reset sequencer with configuration capture, lock detection and low-power divider
// Summary of operation
// [R1] The outside party drives valid override levels at least 20 reference cycles before reset output release.
// [R2] The outside party holds the override levels stable until reset output has been released.
// [R3] The outside party releases the override lines within one reference cycle after reset output release.
// [R4] The reset input and override lines pass through two-stage synchronisers before use.
// [R5] In the low-power stop state an asserted reset input resets the sequencer at once, bypassing the synchronisers.
// [R6] The outside party holds reset asserted at least 100 ns when it asserts it during stop.
// [R7] Lock is expected within 50000 reference cycles, and a sticky timeout flag shows when it is missed.
// [R8] The PLL is judged locked when the measured count lies within two percent of the target.
// [R9] Lock is dropped when the measured count departs by more than four percent from the target.
// [R10] The outside configuration keeps the PLL system clock at 150 MHz or more when the PLL is enabled.
// [R11] The low-power divider supports ratios up to 32768 of the input clock.
// [R12] Reset output stays asserted until reset input is released and lock is reported, then the release sequence runs.
`default_nettype none
module rcpl_top
  import rcpl_pkg::*;
#(
  parameter int unsigned LockCycles = LOCK_MAX_CYC
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             extResetN,
  input  wire logic             stopMode,
  input  wire logic [CFG_W-1:0] cfgOverrideIn,
  input  wire rcpl_meas_t       pllMeas,
  input  wire logic [15:0]      pllTarget,
  input  wire logic [15:0]      lpDivRatio,
  output logic                  resetOutputN,
  output logic [CFG_W-1:0]      cfgLatched,
  output logic                  cfgPinsFree,
  output logic                  pllLocked,
  output logic                  lockTimeout,
  output logic                  lpClkEn
);

  logic [1:0]       rstSync;
  logic [CFG_W-1:0] cfgSync1;
  logic [CFG_W-1:0] cfgSync2;
  rcpl_state_t      state;
  rcpl_state_t      next_state;
  logic [4:0]       setupCnt;
  logic [15:0]      waitCnt;
  logic [15:0]      divCnt;

  // Stop-state bypass of the reset synchroniser
  wire stopRst  = stopMode & ~extResetN;
  wire seqArstN = nrst & ~stopRst; // R5

  // Two-stage synchronisers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync  <= 2'h0;
      cfgSync1 <= CFG_RST;
      cfgSync2 <= CFG_RST;
    end else begin
      rstSync  <= {rstSync[0], extResetN}; // R4
      cfgSync1 <= cfgOverrideIn; // R4
      cfgSync2 <= cfgSync1; // R4
    end
  end

  wire rstReleased = rstSync[1];

  // Lock window arithmetic
  wire        measHigh    = pllMeas.count >= pllTarget;
  wire [15:0] measDiff    = measHigh ? (pllMeas.count - pllTarget) : (pllTarget - pllMeas.count);
  wire [22:0] diffLock    = 23'(measDiff) * 23'(LOCK_DIV);
  wire [22:0] diffUnlock  = 23'(measDiff) * 23'(UNLOCK_DIV);
  wire        inLockWin   = diffLock <= 23'(pllTarget); // R8
  wire        outUnlockWin = diffUnlock > 23'(pllTarget); // R9
  wire        next_locked = pllMeas.valid ? (pllLocked ? ~outUnlockWin : inLockWin) : pllLocked;

  // Lock wait watchdog
  wire        waitDone  = waitCnt == 16'(LockCycles - 1);
  wire [15:0] next_wait = (pllLocked || waitDone) ? waitCnt : waitCnt + 16'h1;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pllLocked   <= 1'b0;
      waitCnt     <= 16'h0;
      lockTimeout <= 1'b0;
    end else begin
      pllLocked   <= next_locked; // R8 R9
      waitCnt     <= next_wait; // R7
      lockTimeout <= lockTimeout | (waitDone & ~pllLocked); // R7
    end
  end

  // Low-power divider, ratio clamped to 1..32768
  wire [15:0] effRatio = (lpDivRatio == 16'h0) ? LP_DIV_MIN :
                         (lpDivRatio > LP_DIV_MAX) ? LP_DIV_MAX : lpDivRatio; // R11
  wire        divWrap  = divCnt >= effRatio - 16'h1;
  wire [15:0] next_div = divWrap ? 16'h0 : divCnt + 16'h1;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      divCnt  <= 16'h0;
      lpClkEn <= 1'b0;
    end else begin
      divCnt  <= next_div; // R11
      lpClkEn <= divWrap; // R11
    end
  end

  // Release sequencer
  wire setupDone = setupCnt == SETUP_LAST;

  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (rstReleased && pllLocked) begin
          next_state = ST_SETUP; // R12
        end
      end
      ST_SETUP: begin
        if (!rstReleased || !pllLocked) begin
          next_state = ST_HOLD; // R12
        end else if (setupDone) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!rstReleased) begin
          next_state = ST_HOLD;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
  end

  wire [4:0] next_setup = (state == ST_SETUP) ? setupCnt + 5'h1 : 5'h0;
  wire       captureNow = (state == ST_SETUP) && (next_state == ST_RUN);

  always_ff @(posedge core_clk or negedge seqArstN) begin
    if (!seqArstN) begin
      state        <= ST_HOLD;
      setupCnt     <= 5'h0;
      resetOutputN <= RST_OUT_RST;
      cfgLatched   <= CFG_RST;
      cfgPinsFree  <= 1'b0;
    end else begin
      state        <= next_state;
      setupCnt     <= next_setup;
      resetOutputN <= next_state == ST_RUN; // R12
      cfgLatched   <= captureNow ? cfgSync2 : cfgLatched; // R4
      cfgPinsFree  <= resetOutputN; // R3
    end
  end

  // Checks
  sequence seqDivTwo;
    !lpClkEn ##1 lpClkEn;
  endsequence

  sequence seqDivTwoArm;
    (lpClkEn && effRatio == 16'h2) ##1 (effRatio == 16'h2);
  endsequence

  sequence seqSetupRun;
    (state == ST_SETUP) ##1 resetOutputN;
  endsequence

  AST_SYNC_PATH: assert property (@(posedge core_clk) disable iff (!nrst) // R4
    !extResetN |-> ##2 !rstReleased)
    else $error("Reset input not seen two cycles later");

  AST_CFG_CAPTURE: assert property (@(posedge core_clk) disable iff (!nrst) // R4
    $rose(resetOutputN) |-> cfgLatched == $past(cfgSync2))
    else $error("Override levels not captured at release");

  AST_STOP_BYPASS: assert property (@(posedge core_clk) disable iff (!nrst) // R5
    (stopMode && !extResetN) |-> (!resetOutputN && state == ST_HOLD))
    else $error("Stop reset did not act at once");

  AST_LOCK_TIMEOUT: assert property (@(posedge core_clk) disable iff (!nrst) // R7
    $rose(lockTimeout) |-> ($past(waitCnt) == 16'(LockCycles - 1) && !$past(pllLocked)))
    else $error("Lock timeout raised at wrong count");

  AST_LOCK_ENTER: assert property (@(posedge core_clk) disable iff (!nrst) // R8
    (pllMeas.valid && !pllLocked &&
     32'(pllMeas.count) * 32'(LOCK_DIV) <= 32'(pllTarget) * 32'(LOCK_DIV + 1) &&
     32'(pllMeas.count) * 32'(LOCK_DIV) >= 32'(pllTarget) * 32'(LOCK_DIV - 1)) |=> pllLocked)
    else $error("Lock not declared inside two percent window");

  AST_UNLOCK: assert property (@(posedge core_clk) disable iff (!nrst) // R9
    (pllMeas.valid &&
     (32'(pllMeas.count) * 32'(UNLOCK_DIV) > 32'(pllTarget) * 32'(UNLOCK_DIV + 1) ||
      32'(pllMeas.count) * 32'(UNLOCK_DIV) < 32'(pllTarget) * 32'(UNLOCK_DIV - 1))) |=> !pllLocked)
    else $error("Lock not dropped beyond four percent");

  AST_LOCK_HOLD: assert property (@(posedge core_clk) disable iff (!nrst) // R9
    (pllLocked && pllMeas.valid && !outUnlockWin) |=> pllLocked)
    else $error("Lock dropped inside four percent window");

  AST_DIV_TWO: assert property (@(posedge core_clk) disable iff (!nrst) // R11
    seqDivTwoArm |-> seqDivTwo)
    else $error("Divide by two period wrong");

  AST_RELEASE_ORDER: assert property (@(posedge core_clk) disable iff (!seqArstN) // R12
    $rose(resetOutputN) |-> ($past(state) == ST_SETUP && $past(setupCnt) == SETUP_LAST && $past(pllLocked)))
    else $error("Reset output released without full setup");

  AST_SETUP_RUN: assert property (@(posedge core_clk) disable iff (!seqArstN) // R12
    (state == ST_SETUP && setupDone && rstReleased && pllLocked) |-> seqSetupRun)
    else $error("Setup end did not release reset output");

  AST_PINS_FREE: assert property (@(posedge core_clk) disable iff (!seqArstN) // R3
    $rose(resetOutputN) |=> cfgPinsFree)
    else $error("Override pins not freed one cycle after release");

  AST_PINS_AFTER: assert property (@(posedge core_clk) disable iff (!seqArstN) // R3
    cfgPinsFree |-> $past(resetOutputN))
    else $error("Override pins freed before release");

  AST_HOLD_LOW: assert property (@(posedge core_clk) disable iff (!seqArstN) // R12
    !rstReleased |=> !resetOutputN)
    else $error("Reset output released while reset input held");

  AST_WAIT_BOUND: assert property (@(posedge core_clk) disable iff (!nrst) // R7
    waitCnt <= 16'(LockCycles - 1))
    else $error("Lock wait counter ran past its limit");

  AST_TIMEOUT_STICKY: assert property (@(posedge core_clk) disable iff (!nrst) // R7
    lockTimeout |=> lockTimeout)
    else $error("Lock timeout flag cleared without reset");

  AST_DIV_BOUND: assert property (@(posedge core_clk) disable iff (!nrst) // R11
    divCnt < LP_DIV_MAX)
    else $error("Divider counter beyond largest ratio");

endmodule : rcpl_top
`default_nettype wire

// ### dv/rcpl_partner.sv
// Model of the reset source and configuration drivers
`default_nettype none
module rcpl_partner
  import rcpl_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             holdReset,
  input  wire logic [CFG_W-1:0] cfgVal,
  input  wire logic             resetOutputN,
  output logic                  extResetN,
  output logic [CFG_W-1:0]      cfgOverrideIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic             relSeen = 1'b0;
  logic [CFG_W-1:0] junk = 8'h5a;
  always @(posedge core_clk) begin
    extResetN <= ~holdReset;
    relSeen   <= resetOutputN;
    junk      <= ~junk;
  end
  // Held until release, then let go within a cycle
  assign cfgOverrideIn = relSeen ? junk : cfgVal;
endmodule : rcpl_partner
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the reset, configuration and lock block
`default_nettype none
module testbench
  import rcpl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LC = 50;
  logic             core_clk = 1'b0;
  logic             nrst = 1'b0;
  logic             holdReset = 1'b1;
  logic             stopMode = 1'b0;
  logic [CFG_W-1:0] cfgVal = 8'h00;
  rcpl_meas_t       pllMeas = '0;
  logic [15:0]      pllTarget = 16'h1000;
  logic [15:0]      lpDivRatio = 16'h0001;
  logic [31:0]      seed = 32'h31f3;
  logic             measPrev = 1'b0, roPrev = 1'b0, roPrev2 = 1'b0;
  logic             extResetN, resetOutputN, cfgPinsFree, pllLocked, lockTimeout, lpClkEn;
  logic [CFG_W-1:0] cfgOverrideIn, cfgLatched;
  logic [CFG_W-1:0] cfgQ[$];
  logic             lockQ[$];
  logic [15:0]      ratios[4] = '{16'h0000, 16'h0002, 16'h0003, 16'hffff};
  int               err_count = 0;
  int               total_checks = 0;
  int               n;
  int               pulses;
  always #10 core_clk = ~core_clk;
  rcpl_partner u_rcpl_partner (.core_clk(core_clk), .holdReset(holdReset), .cfgVal(cfgVal),
    .resetOutputN(resetOutputN), .extResetN(extResetN), .cfgOverrideIn(cfgOverrideIn));
  rcpl_top #(.LockCycles(LC)) u_rcpl_top (.core_clk(core_clk), .nrst(nrst), .extResetN(extResetN),
    .stopMode(stopMode), .cfgOverrideIn(cfgOverrideIn), .pllMeas(pllMeas), .pllTarget(pllTarget),
    .lpDivRatio(lpDivRatio), .resetOutputN(resetOutputN), .cfgLatched(cfgLatched),
    .cfgPinsFree(cfgPinsFree), .pllLocked(pllLocked), .lockTimeout(lockTimeout), .lpClkEn(lpClkEn));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic meas(input int pm, input logic expLock);
    @(posedge core_clk);
    pllMeas <= '{1'b1, 16'(int'(pllTarget) * (1000 + pm) / 1000)};
    lockQ.push_back(expLock);
    @(posedge core_clk);
    pllMeas.valid <= 1'b0;
  endtask : meas
  task automatic nextCfg();
    seed = xs(seed);
    cfgVal <= seed[7:0];
    cfgQ.push_back(seed[7:0]);
  endtask : nextCfg
  task automatic waitRise();
    for (n = 0; n < 40 && resetOutputN !== 1'b1; n++) @(posedge core_clk);
    check(16'(n >= 19 && n < 40), 16'h0001);
  endtask : waitRise
  always @(posedge core_clk) begin
    if (measPrev) check(16'(pllLocked), 16'(lockQ.pop_front()));
    if (resetOutputN === 1'b1 && !roPrev) check(16'(cfgLatched), 16'(cfgQ.pop_front()));
    if (resetOutputN === 1'b1 && !roPrev) check(16'(cfgPinsFree), 16'h0000);
    if (roPrev && !roPrev2) check(16'(cfgPinsFree), 16'h0001);
    measPrev <= pllMeas.valid;
    roPrev   <= resetOutputN;
    roPrev2  <= roPrev;
  end
  initial begin
    #1800000;
    err_count++;
    complete_run();
  end
  initial begin
    nextCfg();
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    seed = xs(seed);
    pllTarget <= 16'h0800 + 16'(seed[10:0]);
    holdReset <= 1'b0;
    repeat (LC + 3) @(posedge core_clk);
    check(16'(lockTimeout), 16'h0001);
    check(16'(resetOutputN), 16'h0000);
    meas(30, 1'b0);
    meas(-50, 1'b0);
    meas(10, 1'b1);
    waitRise();
    meas(30, 1'b1);
    meas(-50, 1'b0);
    check(16'(resetOutputN), 16'h0001);
    meas(-10, 1'b1);
    holdReset <= 1'b1;
    nextCfg();
    repeat (6) @(posedge core_clk);
    check(16'(resetOutputN), 16'h0000);
    holdReset <= 1'b0;
    repeat (10) @(posedge core_clk);
    meas(-50, 1'b0);
    repeat (25) @(posedge core_clk);
    check(16'(resetOutputN), 16'h0000);
    meas(0, 1'b1);
    waitRise();
    stopMode <= 1'b1;
    @(posedge core_clk);
    holdReset <= 1'b1;
    @(posedge core_clk);
    #1;
    check(16'(resetOutputN), 16'h0000);
    check(16'(cfgLatched), 16'h0000);
    repeat (6) @(posedge core_clk);
    stopMode <= 1'b0;
    holdReset <= 1'b0;
    cfgQ.push_back(cfgVal);
    repeat (2) @(posedge core_clk);
    waitRise();
    foreach (ratios[i]) begin
      lpDivRatio <= ratios[i];
      n = (ratios[i] == 16'h0000) ? 1 : ((ratios[i] > LP_DIV_MAX) ? 32768 : int'(ratios[i]));
      repeat (n + 1) @(posedge core_clk);
      pulses = 0;
      repeat (n) begin
        @(posedge core_clk);
        pulses += int'(lpClkEn);
      end
      check(16'(pulses), 16'h0001);
    end
    complete_run();
  end
endmodule : testbench
`default_nettype wire
